//--- rtl/adc_scan_mode_decoder.sv
// Purpose: decodes scan code and channel pick of the mode control word
// Assumes: words arrive as one-cycle strobes after deserialising
// Notes:   custom set registers are loaded elsewhere and given as inputs
//          code and pick are stored on the strobe edge, setup one edge later
//          the custom summary follows the set registers while a custom
//          mode is held, so a rewrite of the set shows without a new word
//          codes 0001 to 0011 belong to modes outside this block; here
//          they keep the mode and leave the low fields alone
//          averaging is only ever granted in the internal clock modes;
//          the grant is registered so it settles with the setup word
//          CHANNELS, 16 or 8, sets the top channel to 15 or 7; a pick above the top
//          on a smaller part is the host's fault and is not trapped
//          reset release runs through two flops, so the first word
//          is taken on the third edge after the pin rises
// Contract
// RULE1: code 0100: inputs 0 up to the pick, ext clock, no averaging.
// RULE2: code 0101: pick to top, int clock, may average, 16-N or 8-N results.
// RULE3: code 0110: pick to top, ext clock, no averaging.
// RULE4: code 0111: custom set ascending, int clock, may average, up to 16.
// RULE5: code 1000: custom set ascending, ext clock, no averaging, up to 16.
// RULE6: custom modes take members from the two set registers, not the pick.
// RULE7: code 1001: programmable sequence up to 256, ext clock, no averaging.
// RULE8: codes 1010 to 1111 keep the previous mode and ignore bits 10 to 0.
// RULE9: the channel pick is an unsigned channel number, 0 to 15.
// RULE10: code 0000 keeps the mode but still loads bits 6 to 3 and bit 1.
`timescale 1ns/1ps
`include "scan_decoder_regs.svh"
module adc_scan_mode_decoder #(
	parameter int CHANNELS = 16
) (
	// clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         arst_n,
	// control word strobe
	input  wire scan_decoder_pkg::ctrl_word_t ctrlWord,
	// custom set registers
	input  wire logic [7:0]                   custom_set_low_reg,
	input  wire logic [7:0]                   custom_set_high_reg,
	// programmable sequence length and averaging request
	input  wire logic [8:0]                   progLength,
	input  wire logic                         avgRequest,
	// decoded setup
	output scan_decoder_pkg::scan_setup_t     setup,
	output logic                              avgActive,
	output logic [3:0]                        lowField,
	output logic                              lowBit,
	output logic                              modeChanged
);
	import scan_decoder_pkg::*;

	logic        rstSync1Reg;
	logic        rstSync2Reg;
	logic [3:0]  scanCodeReg;
	logic [3:0]  chanPickReg;
	logic [3:0]  lowFieldReg;
	logic        lowBitReg;
	logic        changedReg;
	logic        avgActiveReg;
	scan_setup_t setupReg;
	scan_setup_t setupNext;
	logic [3:0]  codeIn;
	logic [3:0]  pickIn;
	logic        isModeCode;
	logic [15:0] customMask;
	logic [4:0]  customCount;
	logic [3:0]  customLow;
	logic [3:0]  customHigh;
	logic [3:0]  topChannel;
	logic        rstInt_n;

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync1Reg <= 1'b0;
			rstSync2Reg <= 1'b0;
		end else begin
			rstSync1Reg <= 1'b1;
			rstSync2Reg <= rstSync1Reg;
		end
	end
	assign rstInt_n = rstSync2Reg;

	// field extraction
	assign codeIn = ctrlWord.word[`SCAN_CODE_MSB:`SCAN_CODE_LSB];
	assign pickIn = ctrlWord.word[`CHAN_PICK_MSB:`CHAN_PICK_LSB]; // RULE9
	assign topChannel = 4'(CHANNELS - 1);
	assign customMask = {custom_set_high_reg, custom_set_low_reg}; // RULE6

	// codes that carry a new scan mode
	always_comb begin
		case (codeIn)
			`SCAN_CODE_STD_EXT, `SCAN_CODE_UP_INT, `SCAN_CODE_UP_EXT,
			`SCAN_CODE_CU_INT, `SCAN_CODE_CU_EXT, `SCAN_CODE_PROG: begin
				isModeCode = 1'b1;
			end
			default: begin
				isModeCode = 1'b0; // RULE8
			end
		endcase
	end

	channel_set_count #(
		.CHANNELS (16)
	) u_set_count (
		.setMask     (customMask),
		.memberCount (customCount),
		.lowChannel  (customLow),
		.highChannel (customHigh)
	);

	// stored code and channel pick, kept on null codes
	always_ff @(posedge sys_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			scanCodeReg <= `RESET_SCAN_CODE;
			chanPickReg <= `RESET_CHAN_PICK;
		end else if (ctrlWord.valid && isModeCode) begin
			scanCodeReg <= codeIn;
			chanPickReg <= pickIn; // RULE8
		end
	end

	// low fields written by code 0000 and by mode codes
	always_ff @(posedge sys_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			lowFieldReg <= `RESET_LOW_FIELD;
			lowBitReg   <= 1'b0;
		end else if (ctrlWord.valid &&
			(isModeCode || codeIn == `SCAN_CODE_NULL)) begin
			lowFieldReg <= ctrlWord.word[`KEEP_FIELD_MSB:`KEEP_FIELD_LSB]; // RULE10
			lowBitReg   <= ctrlWord.word[`KEEP_BIT_POS]; // RULE10
		end
	end

	// decode stored code into a scan setup
	always_comb begin
		setupNext = '0;
		setupNext.mode = SEQ_IDLE;
		case (scanCodeReg)
			`SCAN_CODE_STD_EXT: begin
				setupNext.mode         = SEQ_STDEXT;
				setupNext.extClock     = 1'b1; // RULE1
				setupNext.firstChannel = 4'h0; // RULE1
				setupNext.lastChannel  = chanPickReg; // RULE1
				setupNext.resultCount  = {5'h00, chanPickReg} + 9'h001;
			end
			`SCAN_CODE_UP_INT: begin
				setupNext.mode         = SEQ_UPINT;
				setupNext.avgAllowed   = 1'b1; // RULE2
				setupNext.firstChannel = chanPickReg;
				setupNext.lastChannel  = topChannel;
				setupNext.resultCount  = 9'(CHANNELS) -
					{5'h00, chanPickReg}; // RULE2
			end
			`SCAN_CODE_UP_EXT: begin
				setupNext.mode         = SEQ_UPEXT;
				setupNext.extClock     = 1'b1; // RULE3
				setupNext.firstChannel = chanPickReg; // RULE3
				setupNext.lastChannel  = topChannel; // RULE3
				setupNext.resultCount  = 9'(CHANNELS) -
					{5'h00, chanPickReg};
			end
			`SCAN_CODE_CU_INT: begin
				setupNext.mode         = SEQ_CUINT;
				setupNext.avgAllowed   = 1'b1; // RULE4
				setupNext.customSet    = 1'b1; // RULE6
				setupNext.firstChannel = customLow;
				setupNext.lastChannel  = customHigh;
				setupNext.resultCount  = {4'h0, customCount}; // RULE4
			end
			`SCAN_CODE_CU_EXT: begin
				setupNext.mode         = SEQ_CUEXT;
				setupNext.extClock     = 1'b1; // RULE5
				setupNext.customSet    = 1'b1; // RULE6
				setupNext.firstChannel = customLow;
				setupNext.lastChannel  = customHigh;
				setupNext.resultCount  = {4'h0, customCount}; // RULE5
			end
			`SCAN_CODE_PROG: begin
				setupNext.mode         = SEQ_PROG;
				setupNext.extClock     = 1'b1; // RULE7
				setupNext.programmableSequenceMode = 1'b1; // RULE7
				setupNext.resultCount  = (progLength > `MAX_PROG_LEN) ?
					`MAX_PROG_LEN : progLength; // RULE7
			end
			default: begin
				setupNext.mode = SEQ_IDLE;
			end
		endcase
	end

	// registered setup output
	always_ff @(posedge sys_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			setupReg <= '0;
		end else begin
			setupReg <= setupNext;
		end
	end

	// pulse when a mode code was accepted
	always_ff @(posedge sys_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			changedReg <= 1'b0;
		end else begin
			changedReg <= ctrlWord.valid && isModeCode;
		end
	end

	// averaging grant, registered alongside the setup it depends on
	always_ff @(posedge sys_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			avgActiveReg <= 1'b0;
		end else begin
			avgActiveReg <= setupNext.avgAllowed & avgRequest; // RULE2 RULE4
		end
	end

	// outputs straight from their registers
	assign setup       = setupReg;
	assign avgActive   = avgActiveReg;
	assign lowField    = lowFieldReg;
	assign lowBit      = lowBitReg;
	assign modeChanged = changedReg;
endmodule : adc_scan_mode_decoder

//--- rtl/scan_decoder_regs.svh
// Purpose: offsets, field positions, reset values for the scan decoder
// Assumes: 16-bit mode control word, bit 15 zero selects mode control
// Notes:   definitions only
`ifndef SCAN_DECODER_REGS_SVH
`define SCAN_DECODER_REGS_SVH
`define SCAN_CODE_MSB     14
`define SCAN_CODE_LSB     11
`define CHAN_PICK_MSB     10
`define CHAN_PICK_LSB     7
`define KEEP_FIELD_MSB    6
`define KEEP_FIELD_LSB    3
`define KEEP_BIT_POS      1
`define IGNORED_MSB       10
`define SCAN_CODE_NULL    4'h0
`define SCAN_CODE_STD_EXT 4'h4
`define SCAN_CODE_UP_INT  4'h5
`define SCAN_CODE_UP_EXT  4'h6
`define SCAN_CODE_CU_INT  4'h7
`define SCAN_CODE_CU_EXT  4'h8
`define SCAN_CODE_PROG    4'h9
`define RESET_SCAN_CODE   4'h0
`define RESET_CHAN_PICK   4'h0
`define RESET_LOW_FIELD   4'h0
`define MAX_CUSTOM_CONV   5'h10
`define MAX_PROG_LEN      9'h100
`endif

//--- rtl/scan_decoder_pkg.sv
// Purpose: types for the scan-mode decoder
// Assumes: 16 analog inputs at most
// Notes:   carrier structs for decoded mode
package scan_decoder_pkg;
	typedef enum logic [2:0] {
		SEQ_IDLE   = 3'b000,
		SEQ_STDEXT = 3'b001,
		SEQ_UPINT  = 3'b011,
		SEQ_UPEXT  = 3'b010,
		SEQ_CUINT  = 3'b110,
		SEQ_CUEXT  = 3'b111,
		SEQ_PROG   = 3'b101
	} seq_mode_t;

	typedef struct packed {
		seq_mode_t   mode;
		logic        extClock;
		logic        avgAllowed;
		logic        customSet;
		logic        programmableSequenceMode;
		logic [3:0]  firstChannel;
		logic [3:0]  lastChannel;
		logic [8:0]  resultCount;
	} scan_setup_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] word;
	} ctrl_word_t;
endpackage : scan_decoder_pkg

//--- rtl/channel_set_count.sv
// Purpose: counts members and lowest/highest channel of a custom set
// Assumes: set is a 16-bit mask, bit i is analog input i
// Notes:   purely combinational
`timescale 1ns/1ps
module channel_set_count #(
	parameter int CHANNELS = 16
) (
	// channel membership
	input  wire logic [CHANNELS-1:0] setMask,
	// summary
	output logic [4:0]               memberCount,
	output logic [3:0]               lowChannel,
	output logic [3:0]               highChannel
);
	logic [4:0] partial [CHANNELS:0];

	assign partial[0] = 5'h00;
	// running population count, one stage per channel
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_cnt
			assign partial[g+1] = partial[g] + {4'h0, setMask[g]};
		end
	endgenerate
	assign memberCount = partial[CHANNELS];

	// lowest and highest member
	always_comb begin
		lowChannel  = 4'h0;
		highChannel = 4'h0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (setMask[i]) begin
				lowChannel = i[3:0];
			end
		end
		for (int i = 0; i < CHANNELS; i++) begin
			if (setMask[i]) begin
				highChannel = i[3:0];
			end
		end
	end
endmodule : channel_set_count

//--- verif/ctrl_host_model.sv
// Purpose: host side, hands mode words to the decoder
// Assumes: one request cycle gives one word
// Notes:   idle word is the inverse of the last one sent
`timescale 1ns/1ps
module ctrl_host_model (
	// clock
	input  wire logic                    sys_clk,
	// bench request
	input  wire logic                    req,
	input  wire logic [15:0]             reqWord,
	// word strobe
	output scan_decoder_pkg::ctrl_word_t ctrlWord
);
	import scan_decoder_pkg::*;
	// one-cycle strobe, bit 15 low selects mode control
	always_ff @(posedge sys_clk) begin
		ctrlWord <= req ? {2'b10, reqWord[14:0]} : {1'b0, ~reqWord};
	end
endmodule : ctrl_host_model

//--- verif/adc_scan_mode_decoder_chk.sv
// Purpose: decode and timing checks at the decoder ports
// Assumes: setup lands one edge after the edge that takes the word
// Notes:   bound to every decoder
`timescale 1ns/1ps
module adc_scan_mode_decoder_chk #(
	parameter int CHANNELS = 16
) (
	// clock and reset
	input wire logic                          sys_clk,
	input wire logic                          arst_n,
	// watched ports
	input wire scan_decoder_pkg::ctrl_word_t  ctrlWord,
	input wire logic                          avgRequest,
	input wire scan_decoder_pkg::scan_setup_t setup,
	input wire logic                          avgActive,
	input wire logic [3:0]                    lowField,
	input wire logic                          lowBit,
	input wire logic                          modeChanged
);
	import scan_decoder_pkg::*;
	logic [3:0] pick;
	logic [3:0] lowIn;
	logic       bitIn;
	logic [3:0] code;
	// word fields
	assign pick = ctrlWord.word[10:7];
	assign lowIn = ctrlWord.word[6:3];
	assign bitIn = ctrlWord.word[1];
	assign code = ctrlWord.word[14:11];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// a taken word with a given code
	sequence took(logic [3:0] c);
		ctrlWord.valid && code == c;
	endsequence
	chk_std_range: assert property (took(4'h4) |=> modeChanged ##1
		setup.mode == SEQ_STDEXT && setup.extClock && !setup.avgAllowed
		&& setup.firstChannel == 4'h0 && setup.lastChannel == $past(pick, 2)
		&& setup.resultCount == $past(pick, 2) + 9'h001) else $error("std");
	chk_up_int: assert property (took(4'h5) |=> ##1
		setup.mode == SEQ_UPINT && !setup.extClock && setup.avgAllowed
		&& setup.lastChannel == CHANNELS - 1
		&& setup.resultCount == CHANNELS - $past(pick, 2)) else $error("upi");
	chk_up_ext: assert property (took(4'h6) |=> ##1
		setup.mode == SEQ_UPEXT && setup.extClock && !setup.avgAllowed
		&& setup.firstChannel == $past(pick, 2)) else $error("upe");
	chk_cu_int: assert property (took(4'h7) |=> ##1
		setup.mode == SEQ_CUINT && setup.customSet && setup.avgAllowed
		&& setup.resultCount <= 9'h010) else $error("cui");
	chk_cu_ext: assert property (took(4'h8) |=> ##1
		setup.mode == SEQ_CUEXT && setup.customSet && setup.extClock
		&& !setup.avgAllowed) else $error("cue");
	chk_prog_seq: assert property (took(4'h9) |=> ##1
		setup.mode == SEQ_PROG && setup.programmableSequenceMode
		&& setup.extClock && setup.resultCount <= 9'h100) else $error("prg");
	chk_null_keep: assert property (ctrlWord.valid && code > 4'h9
		|=> !modeChanged && $stable(lowField) && $stable(lowBit))
		else $error("null");
	chk_low_load: assert property (ctrlWord.valid
		&& (code == 4'h0 || (code > 4'h3 && code < 4'hA))
		|=> lowField == $past(lowIn) && lowBit == $past(bitIn))
		else $error("low");
	chk_avg_gate: assert property (
		avgActive == (setup.avgAllowed && $past(avgRequest)))
		else $error("avg");
endmodule : adc_scan_mode_decoder_chk
bind adc_scan_mode_decoder adc_scan_mode_decoder_chk #(.CHANNELS(CHANNELS))
	u_adc_scan_mode_decoder_chk (.sys_clk, .arst_n, .ctrlWord, .avgRequest,
	.setup, .avgActive, .lowField, .lowBit, .modeChanged);

//--- verif/adc_scan_mode_decoder_test.sv
// Purpose: self-checking run of the scan decoder
// Assumes: words reach the decoder through the host model
// Notes:   waits follow the fixed hand-over latencies
`timescale 1ns/1ps
module adc_scan_mode_decoder_test;
	import scan_decoder_pkg::*;
	logic        sys_clk    = 1'b0;
	logic        arst_n     = 1'b0;
	logic        req        = 1'b0;
	logic [15:0] reqWord    = 16'h0000;
	logic [7:0]  setLow     = 8'h00;
	logic [7:0]  setHigh    = 8'h00;
	logic [8:0]  progLength = 9'h000;
	logic        avgRequest = 1'b1;
	logic        pulse;
	ctrl_word_t  ctrlWord;
	scan_setup_t setup;
	logic        avgActive;
	logic [3:0]  lowField;
	logic        lowBit;
	logic        modeChanged;
	int          errors     = 0;
	int          n_tests    = 0;
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	ctrl_host_model u_ctrl_host_model (.sys_clk, .req, .reqWord, .ctrlWord);
	adc_scan_mode_decoder u_adc_scan_mode_decoder (.sys_clk, .arst_n,
		.ctrlWord, .custom_set_low_reg(setLow), .custom_set_high_reg(setHigh),
		.progLength, .avgRequest, .setup, .avgActive, .lowField, .lowBit,
		.modeChanged);
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	function automatic logic [15:0] mk(input logic [3:0] c,
		input logic [3:0] p, input logic [4:0] lo);
		return {1'b0, c, p, lo[4:1], 1'b0, lo[0], 1'b0};
	endfunction : mk
	// one word through the model, then wait until setup has landed
	task automatic send(input logic [15:0] w);
		@(posedge sys_clk) #1;
		req = 1'b1;
		reqWord = w;
		@(posedge sys_clk) #1;
		req = 1'b0;
		@(posedge sys_clk) #1;
		pulse = modeChanged;
		@(posedge sys_clk) #1;
	endtask : send
	// flags are ext, avg, custom, programmable
	task automatic chk(input seq_mode_t m, input logic [3:0] fl,
		input logic [3:0] f, input logic [3:0] l, input logic [8:0] n);
		cmp(setup.mode, m);
		cmp({setup.extClock, setup.avgAllowed, setup.customSet,
			setup.programmableSequenceMode}, fl);
		cmp({setup.firstChannel, setup.lastChannel}, {f, l});
		cmp(setup.resultCount, n);
		cmp({pulse, avgActive}, {1'b1, fl[2] & avgRequest});
	endtask : chk
	task automatic t_range;
		send(mk(4'h4, 4'h0, 5'h00));
		chk(SEQ_STDEXT, 4'h8, 4'h0, 4'h0, 9'h001);
		send(mk(4'h4, 4'hF, 5'h00));
		chk(SEQ_STDEXT, 4'h8, 4'h0, 4'hF, 9'h010);
		send(mk(4'h5, 4'h5, 5'h00));
		chk(SEQ_UPINT, 4'h4, 4'h5, 4'hF, 9'h00B);
		avgRequest = 1'b0;
		send(mk(4'h5, 4'h0, 5'h00));
		chk(SEQ_UPINT, 4'h4, 4'h0, 4'hF, 9'h010);
		avgRequest = 1'b1;
		send(mk(4'h6, 4'hF, 5'h00));
		chk(SEQ_UPEXT, 4'h8, 4'hF, 4'hF, 9'h001);
	endtask : t_range
	task automatic t_custom;
		setLow = 8'h12;
		setHigh = 8'h80;
		send(mk(4'h7, 4'h9, 5'h00));
		chk(SEQ_CUINT, 4'h6, 4'h1, 4'hF, 9'h003);
		send(mk(4'h8, 4'h2, 5'h00));
		chk(SEQ_CUEXT, 4'hA, 4'h1, 4'hF, 9'h003);
		setLow = 8'hFF;
		setHigh = 8'hFF;
		send(mk(4'h8, 4'h2, 5'h00));
		chk(SEQ_CUEXT, 4'hA, 4'h0, 4'hF, 9'h010);
	endtask : t_custom
	task automatic t_prog;
		progLength = 9'h1FF;
		send(mk(4'h9, 4'h7, 5'h00));
		chk(SEQ_PROG, 4'h9, 4'h0, 4'h0, 9'h100);
	endtask : t_prog
	// reserved codes keep all, code zero loads the low fields only
	task automatic t_null;
		for (int c = 10; c < 16; c++) begin
			send(mk(4'(c), 4'hA, 5'h1F));
			cmp({pulse, lowField, lowBit, setup.mode}, {6'h00, SEQ_PROG});
		end
		send(mk(4'h0, 4'h3, 5'h15));
		cmp({pulse, lowField, lowBit, setup.mode}, {6'h15, SEQ_PROG});
	endtask : t_null
	task automatic give_verdict;
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge sys_clk);
		t_range();
		t_custom();
		t_prog();
		t_null();
		give_verdict();
	end
	// hang guard
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule : adc_scan_mode_decoder_test
